// >>> hw/lpc_device.sv
// Memory die end of one channel: command capture, mode bits, data path
`timescale 1ns/1ns
module lpc_device import lpc_pkg::*; (
	// Link to the controller
	lpc_link_if.dev link,
	// Signalling mode strap, high for the low-voltage variant
	input wire logic lp4x_mode,
	// Status
	output logic power_down,
	output logic ca_term_on,
	output logic cs_term_on,
	output logic ck_term_on,
	output logic [CA_W-1:0] last_cmd
);

	// Own clock pair per channel instance; true edge is the sample point
	logic clk;
	assign clk = link.clock_true;

	// Reset pin synchroniser, no reset of its own
	logic [2:0] rst_sync_ff;
	logic rst_ok_ff;
	logic nxt_rst_ok;

	// Command state
	lpc_dev_st_e st_ff, nxt_st;
	logic [1:0] mr_idx_ff, nxt_mr_idx;
	logic [CA_W-1:0] term_mr_ff, nxt_term_mr;
	logic [CA_W-1:0] termx_mr_ff, nxt_termx_mr;
	logic [CA_W-1:0] data_mr_ff, nxt_data_mr;
	logic [CA_W-1:0] last_cmd_ff, nxt_last_cmd;

	// Read and write pipelines
	logic [1:0] wr_v_ff, nxt_wr_v;
	logic [1:0] rd_v_ff, nxt_rd_v;
	logic [WADDR_W-1:0] wr_a0_ff, wr_a1_ff, nxt_wr_a0, nxt_wr_a1;
	logic [WADDR_W-1:0] rd_a0_ff, rd_a1_ff, nxt_rd_a0, nxt_rd_a1;

	// Output drive registers
	logic oe_ff, nxt_oe;
	logic [DQ_W-1:0] dq_ff, nxt_dq;
	logic [LANES-1:0] dqs_ff, nxt_dqs;
	logic [LANES-1:0] dmi_ff, nxt_dmi;
	logic ca_term_ff, cs_term_ff, ck_term_ff;
	logic nxt_ca_term, nxt_cs_term, nxt_ck_term;

	// Storage
	logic [DQ_W-1:0] mem_ff [0:WORDS-1];
	logic [DQ_W-1:0] nxt_mem [0:WORDS-1];

	// Lane data path
	logic dbi_en, mask_mode;
	logic [DQ_W-1:0] wr_word, rd_word, rd_src;
	logic [LANES-1:0] wr_keep, rd_inv;

	// Decoded command fields
	logic [2:0] op;
	logic [2:0] arg;
	assign op = link.cmd_addr_bus[5:3];
	assign arg = link.cmd_addr_bus[2:0];

	// Flag meaning chosen by mode register; mask wins over inversion
	assign mask_mode = data_mr_ff[DATA_MASK_BIT];
	assign dbi_en = data_mr_ff[DATA_DBI_BIT] & ~mask_mode;
	assign rd_src = mem_ff[rd_a1_ff];

	// One lane each: undo inversion, honour mask, encode reads
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [LANE_W-1:0] din;
		logic [LANE_W-1:0] rsrc;
		assign din = link.dq[l*LANE_W +: LANE_W];
		assign rsrc = rd_src[l*LANE_W +: LANE_W];
		assign wr_keep[l] = ~(mask_mode & link.byte_invert_mask[l]);
		assign wr_word[l*LANE_W +: LANE_W] =
			(dbi_en & link.byte_invert_mask[l]) ? ~din : din;
		assign rd_inv[l] = dbi_en & ($countones(rsrc) > INV_LIMIT);
		assign rd_word[l*LANE_W +: LANE_W] = rd_inv[l] ? ~rsrc : rsrc;
	end

	// Reset settles once the last two stages agree
	always_comb begin
		nxt_rst_ok = rst_ok_ff;
		if (rst_sync_ff[1] == rst_sync_ff[2]) begin
			nxt_rst_ok = rst_sync_ff[2];
		end
	end

	always_ff @(posedge clk) begin
		rst_sync_ff <= {rst_sync_ff[1:0], link.reset_n};
		rst_ok_ff <= nxt_rst_ok;
	end

	// Command decoder and mode registers
	always_comb begin
		nxt_st = st_ff;
		nxt_mr_idx = mr_idx_ff;
		nxt_term_mr = term_mr_ff;
		nxt_termx_mr = termx_mr_ff;
		nxt_data_mr = data_mr_ff;
		nxt_last_cmd = last_cmd_ff;
		nxt_wr_v = {wr_v_ff[0], 1'b0};
		nxt_rd_v = {rd_v_ff[0], 1'b0};
		nxt_wr_a0 = wr_a0_ff;
		nxt_wr_a1 = wr_a0_ff;
		nxt_rd_a0 = rd_a0_ff;
		nxt_rd_a1 = rd_a0_ff;
		if (!link.cke) begin
			// Enable low halts everything in flight
			nxt_st = DST_PDOWN;
			nxt_wr_v = 2'h0;
			nxt_rd_v = 2'h0;
		end else begin
			unique case (st_ff)
				DST_PDOWN: begin
					nxt_st = DST_IDLE;
				end
				DST_MRW_DATA: begin
					// Second beat carries the register value
					nxt_st = DST_IDLE;
					if (mr_idx_ff == MR_TERM) begin
						nxt_term_mr = link.cmd_addr_bus;
					end else if (mr_idx_ff == MR_TERMX) begin
						nxt_termx_mr = link.cmd_addr_bus;
					end else if (mr_idx_ff == MR_DATA) begin
						nxt_data_mr = link.cmd_addr_bus;
					end
				end
				DST_IDLE: begin
					if (link.cs) begin
						nxt_last_cmd = link.cmd_addr_bus;
						if (op == OP_WR) begin
							nxt_wr_v[0] = 1'b1;
							nxt_wr_a0 = arg;
						end else if (op == OP_RD) begin
							nxt_rd_v[0] = 1'b1;
							nxt_rd_a0 = arg;
						end else if (op == OP_MRW) begin
							nxt_mr_idx = arg[1:0];
							nxt_st = DST_MRW_DATA;
						end
					end
				end
				default: nxt_st = DST_IDLE;
			endcase
		end
	end

	// Storage update; masked lanes keep their old byte
	always_comb begin
		for (int w = 0; w < WORDS; w++) begin
			nxt_mem[w] = mem_ff[w];
		end
		if (wr_v_ff[1] && link.cke) begin
			for (int l = 0; l < LANES; l++) begin
				if (wr_keep[l]) begin
					nxt_mem[wr_a1_ff][l*LANE_W +: LANE_W] = wr_word[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// Read drive: one preamble period, then data with strobe high
	always_comb begin
		nxt_oe = (rd_v_ff[0] | rd_v_ff[1]) & link.cke;
		nxt_dqs = '0;
		nxt_dq = dq_ff;
		nxt_dmi = '0;
		if (rd_v_ff[1] && link.cke) begin
			nxt_dqs = '1;
			nxt_dq = rd_word;
			nxt_dmi = rd_inv;
		end
	end

	// Termination follows the signalling mode
	always_comb begin
		if (lp4x_mode) begin
			nxt_ca_term = term_mr_ff[TERM_CA_BIT] & termx_mr_ff[X_CA_BIT];
			nxt_cs_term = termx_mr_ff[X_CS_BIT];
			nxt_ck_term = termx_mr_ff[X_CK_BIT];
		end else begin
			nxt_ca_term = term_mr_ff[TERM_CA_BIT] & link.cmd_termination_ctrl;
			nxt_cs_term = 1'b0;
			nxt_ck_term = 1'b0;
		end
	end

	// Single reset for every die register except storage and the reset synchroniser, taken from any state
	always_ff @(posedge clk) begin
		if (!rst_ok_ff) begin
			st_ff <= DST_IDLE;
			mr_idx_ff <= 2'h0;
			term_mr_ff <= MR_RESET;
			termx_mr_ff <= MR_RESET;
			data_mr_ff <= MR_RESET;
			last_cmd_ff <= 6'h00;
			wr_v_ff <= 2'h0;
			rd_v_ff <= 2'h0;
			wr_a0_ff <= 3'h0;
			wr_a1_ff <= 3'h0;
			rd_a0_ff <= 3'h0;
			rd_a1_ff <= 3'h0;
			oe_ff <= 1'b0;
			dq_ff <= 16'h0000;
			dqs_ff <= 2'h0;
			dmi_ff <= 2'h0;
			ca_term_ff <= 1'b0;
			cs_term_ff <= 1'b0;
			ck_term_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			mr_idx_ff <= nxt_mr_idx;
			term_mr_ff <= nxt_term_mr;
			termx_mr_ff <= nxt_termx_mr;
			data_mr_ff <= nxt_data_mr;
			last_cmd_ff <= nxt_last_cmd;
			wr_v_ff <= nxt_wr_v;
			rd_v_ff <= nxt_rd_v;
			wr_a0_ff <= nxt_wr_a0;
			wr_a1_ff <= nxt_wr_a1;
			rd_a0_ff <= nxt_rd_a0;
			rd_a1_ff <= nxt_rd_a1;
			oe_ff <= nxt_oe;
			dq_ff <= nxt_dq;
			dqs_ff <= nxt_dqs;
			dmi_ff <= nxt_dmi;
			ca_term_ff <= nxt_ca_term;
			cs_term_ff <= nxt_cs_term;
			ck_term_ff <= nxt_ck_term;
		end
	end

	// Storage is not cleared by reset, as in a real array
	always_ff @(posedge clk) begin
		for (int w = 0; w < WORDS; w++) begin
			mem_ff[w] <= nxt_mem[w];
		end
	end

	// Pin drives; released whenever no read is in flight
	assign link.d_oe = oe_ff;
	assign link.d_dq = dq_ff;
	assign link.d_dqs_t = dqs_ff;
	assign link.d_dqs_c = ~dqs_ff;
	assign link.d_dmi = dmi_ff;

	// Status
	assign power_down = (st_ff == DST_PDOWN);
	assign ca_term_on = ca_term_ff;
	assign cs_term_on = cs_term_ff;
	assign ck_term_on = ck_term_ff;
	assign last_cmd = last_cmd_ff;

endmodule : lpc_device

// >>> pkg/lpc_pkg.sv
// Shared constants and types for the memory channel pin link
package lpc_pkg;

	// Bus shape of one channel
	localparam int DQ_W = 16;
	localparam int LANES = 2;
	localparam int LANE_W = 8;
	localparam int CA_W = 6;
	localparam int COL_W = 10;
	localparam int COL_DROP = 2;
	localparam int WORDS = 8;
	localparam int WADDR_W = 3;

	// Command opcodes carried on cmd_addr_bus[5:3]
	localparam logic [2:0] OP_WR = 3'h1;
	localparam logic [2:0] OP_RD = 3'h2;
	localparam logic [2:0] OP_MRW = 3'h3;

	// Mode register indices carried on cmd_addr_bus[1:0]
	localparam logic [1:0] MR_TERM = 2'h0;
	localparam logic [1:0] MR_TERMX = 2'h1;
	localparam logic [1:0] MR_DATA = 2'h2;
	localparam logic [5:0] MR_RESET = 6'h00;

	// Field positions inside the mode registers
	localparam int TERM_CA_BIT = 0;
	localparam int X_CS_BIT = 0;
	localparam int X_CK_BIT = 1;
	localparam int X_CA_BIT = 2;
	localparam int DATA_DBI_BIT = 0;
	localparam int DATA_MASK_BIT = 1;

	// A byte with more ones than this goes out inverted
	localparam int INV_LIMIT = 4;

	// Host reset sequence, in link clock periods
	localparam logic [3:0] RST_LOW_TICKS = 4'h4;
	localparam logic [3:0] RST_DONE_TICKS = 4'h9;

	// Host user command kinds
	localparam logic [1:0] HOP_WR = 2'h0;
	localparam logic [1:0] HOP_RD = 2'h1;
	localparam logic [1:0] HOP_MRW = 2'h2;

	typedef enum logic [1:0] {
		DST_IDLE = 2'b00,
		DST_MRW_DATA = 2'b01,
		DST_PDOWN = 2'b10
	} lpc_dev_st_e;

	typedef enum logic [2:0] {
		HST_RESET = 3'b000,
		HST_IDLE = 3'b001,
		HST_WR = 3'b010,
		HST_RD = 3'b011,
		HST_MRW = 3'b100
	} lpc_host_st_e;

endpackage : lpc_pkg

// >>> pkg/lpc_link_if.sv
// Pin link of one memory channel between controller and memory die
`timescale 1ns/1ns
interface lpc_link_if import lpc_pkg::*; ();
	logic clock_true;
	logic clock_complement;
	logic reset_n;
	logic cke;
	logic cs;
	logic [CA_W-1:0] cmd_addr_bus;
	logic cmd_termination_ctrl;
	// Per-party drives of the shared data group
	logic h_oe;
	logic d_oe;
	logic [DQ_W-1:0] h_dq;
	logic [DQ_W-1:0] d_dq;
	logic [LANES-1:0] h_dqs_t;
	logic [LANES-1:0] h_dqs_c;
	logic [LANES-1:0] d_dqs_t;
	logic [LANES-1:0] d_dqs_c;
	logic [LANES-1:0] h_dmi;
	logic [LANES-1:0] d_dmi;
	// Resolved wire levels; an undriven bus reads low
	logic [DQ_W-1:0] dq;
	logic [LANES-1:0] dqs_t;
	logic [LANES-1:0] dqs_c;
	logic [LANES-1:0] byte_invert_mask;

	assign dq = h_oe ? h_dq : (d_oe ? d_dq : '0);
	assign dqs_t = h_oe ? h_dqs_t : (d_oe ? d_dqs_t : '0);
	assign dqs_c = h_oe ? h_dqs_c : (d_oe ? d_dqs_c : '0);
	assign byte_invert_mask = h_oe ? h_dmi : (d_oe ? d_dmi : '0);

	modport host (
		output clock_true, clock_complement, reset_n, cke, cs, cmd_addr_bus,
		output cmd_termination_ctrl, h_oe, h_dq, h_dqs_t, h_dqs_c, h_dmi,
		input dq, dqs_t, dqs_c, byte_invert_mask
	);
	modport dev (
		input clock_true, clock_complement, reset_n, cke, cs, cmd_addr_bus,
		input cmd_termination_ctrl, dq, dqs_t, dqs_c, byte_invert_mask,
		output d_oe, d_dq, d_dqs_t, d_dqs_c, d_dmi
	);
endinterface : lpc_link_if

// >>> hw/lpc_host.sv
// Controller end of one channel: makes the link clock and sequences commands
`timescale 1ns/1ns
module lpc_host import lpc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Link to the memory die
	lpc_link_if.host link,
	// Command request
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [COL_W-1:0] cmd_col,
	input wire logic [DQ_W-1:0] cmd_wdata,
	input wire logic [LANES-1:0] cmd_wmask,
	input wire logic [1:0] cmd_mr_idx,
	input wire logic [CA_W-1:0] cmd_mr_data,
	// Mirror of the mode bits last written to the die, then termination request and sleep
	input wire logic dbi_en,
	input wire logic mask_mode,
	input wire logic cmd_termination_ctrl_req,
	input wire logic sleep,
	// Read answer
	output logic [DQ_W-1:0] rdata,
	output logic rdata_valid
);

	lpc_host_st_e st_ff, nxt_st;
	logic clk_ff, tick;
	logic [3:0] cnt_ff, nxt_cnt;
	logic rstn_pin_ff, nxt_rstn_pin;
	logic cke_ff, nxt_cke;
	logic cs_ff, nxt_cs;
	logic [CA_W-1:0] ca_ff, nxt_ca;
	logic oe_ff, nxt_oe;
	logic [DQ_W-1:0] dq_ff, nxt_dq;
	logic [LANES-1:0] dqs_ff, nxt_dqs;
	logic [LANES-1:0] dmi_ff, nxt_dmi;
	logic [DQ_W-1:0] rdata_ff, nxt_rdata;
	logic rv_ff, nxt_rv;
	logic odt_ff, nxt_odt;
	logic [DQ_W-1:0] wdata_ff, nxt_wdata, enc_word, dec_word;
	logic [LANES-1:0] wmask_ff, nxt_wmask, enc_flag;
	logic dbi_on;

	// Pins change on the edge where the link clock falls
	assign tick = clk_ff;
	assign dbi_on = dbi_en & ~mask_mode;
	assign cmd_ready = (st_ff == HST_IDLE) && tick && cke_ff && !sleep;

	// Per-lane write encoding and read decoding
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [LANE_W-1:0] wb;
		logic [LANE_W-1:0] rb;
		logic inv;
		assign wb = wdata_ff[l*LANE_W +: LANE_W];
		assign rb = link.dq[l*LANE_W +: LANE_W];
		assign inv = dbi_on & ($countones(wb) > INV_LIMIT);
		assign enc_word[l*LANE_W +: LANE_W] = inv ? ~wb : wb;
		assign enc_flag[l] = mask_mode ? wmask_ff[l] : inv;
		assign dec_word[l*LANE_W +: LANE_W] =
			(dbi_on & link.byte_invert_mask[l]) ? ~rb : rb;
	end

	// Command sequencer, one step per link period
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_rstn_pin = rstn_pin_ff;
		nxt_cke = cke_ff;
		nxt_cs = cs_ff;
		nxt_ca = ca_ff;
		nxt_oe = oe_ff;
		nxt_dq = dq_ff;
		nxt_dqs = dqs_ff;
		nxt_dmi = dmi_ff;
		nxt_rdata = rdata_ff;
		nxt_rv = 1'b0;
		nxt_wdata = wdata_ff;
		nxt_wmask = wmask_ff;
		nxt_odt = odt_ff;
		if (tick) begin
			// Termination pin moves with the other pins, never on the die's sample edge
			nxt_odt = cmd_termination_ctrl_req;
			nxt_cnt = cnt_ff + 4'h1;
			nxt_cs = 1'b0;
			unique case (st_ff)
				HST_RESET: begin
					nxt_rstn_pin = (cnt_ff >= RST_LOW_TICKS);
					if (cnt_ff == RST_DONE_TICKS) begin
						nxt_st = HST_IDLE;
					end
				end
				HST_IDLE: begin
					nxt_cnt = 4'h1;
					nxt_cke = !sleep;
					if (cmd_valid && cmd_ready) begin
						nxt_cs = 1'b1;
						nxt_wdata = cmd_wdata;
						nxt_wmask = cmd_wmask;
						// Column bits below the burst boundary stay off the bus
						nxt_ca = {OP_WR, cmd_col[COL_DROP +: WADDR_W]};
						if (cmd_op == HOP_RD) begin
							nxt_ca = {OP_RD, cmd_col[COL_DROP +: WADDR_W]};
							nxt_st = HST_RD;
						end else if (cmd_op == HOP_MRW) begin
							nxt_ca = {OP_MRW, 1'b0, cmd_mr_idx};
							nxt_st = HST_MRW;
						end else begin
							nxt_st = HST_WR;
						end
					end
				end
				HST_WR: begin
					// Strobe preamble leads the data by one period
					nxt_oe = (cnt_ff != 4'h3);
					nxt_dqs = (cnt_ff == 4'h2) ? '1 : '0;
					nxt_dq = enc_word;
					nxt_dmi = enc_flag;
					if (cnt_ff == 4'h3) begin
						nxt_st = HST_IDLE;
					end
				end
				HST_RD: begin
					if (cnt_ff == 4'h3) begin
						nxt_rdata = dec_word;
						nxt_rv = 1'b1;
						nxt_st = HST_IDLE;
					end
				end
				HST_MRW: begin
					nxt_ca = (cnt_ff == 4'h1) ? cmd_mr_data : 6'h00;
					if (cnt_ff == 4'h2) begin
						nxt_st = HST_IDLE;
					end
				end
				default: begin
					nxt_st = HST_RESET;
				end
			endcase
		end
	end

	// Registers; the link clock divider is held low through reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			clk_ff <= 1'b0;
			st_ff <= HST_RESET;
			cnt_ff <= 4'h0;
			rstn_pin_ff <= 1'b0;
			cke_ff <= 1'b0;
			cs_ff <= 1'b0;
			ca_ff <= 6'h00;
			oe_ff <= 1'b0;
			dq_ff <= 16'h0000;
			dqs_ff <= 2'h0;
			dmi_ff <= 2'h0;
			rdata_ff <= 16'h0000;
			rv_ff <= 1'b0;
			odt_ff <= 1'b0;
			wdata_ff <= 16'h0000;
			wmask_ff <= 2'h0;
		end else begin
			clk_ff <= ~clk_ff;
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			rstn_pin_ff <= nxt_rstn_pin;
			cke_ff <= nxt_cke;
			cs_ff <= nxt_cs;
			ca_ff <= nxt_ca;
			oe_ff <= nxt_oe;
			dq_ff <= nxt_dq;
			dqs_ff <= nxt_dqs;
			dmi_ff <= nxt_dmi;
			rdata_ff <= nxt_rdata;
			rv_ff <= nxt_rv;
			odt_ff <= nxt_odt;
			wdata_ff <= nxt_wdata;
			wmask_ff <= nxt_wmask;
		end
	end

	// Pin drives
	assign link.clock_true = clk_ff;
	assign link.clock_complement = ~clk_ff;
	assign link.reset_n = rstn_pin_ff;
	assign link.cke = cke_ff;
	assign link.cs = cs_ff;
	assign link.cmd_addr_bus = ca_ff;
	assign link.cmd_termination_ctrl = odt_ff;
	assign link.h_oe = oe_ff;
	assign link.h_dq = dq_ff;
	assign link.h_dqs_t = dqs_ff;
	assign link.h_dqs_c = ~dqs_ff;
	assign link.h_dmi = dmi_ff;
	assign rdata = rdata_ff;
	assign rdata_valid = rv_ff;

endmodule : lpc_host

// >>> verif/lpc_link_assertions.sv
// Link rule assertions for one memory channel
`timescale 1ns/1ns
module lpc_link_assertions import lpc_pkg::*; (
	// Link clock and die reset
	input wire logic clock_true,
	input wire logic reset_n,
	// Command pins
	input wire logic cke,
	input wire logic cs,
	input wire logic [CA_W-1:0] cmd_addr_bus,
	// Data group, per-party enables and resolved wires
	input wire logic h_oe,
	input wire logic d_oe,
	input wire logic [DQ_W-1:0] dq,
	input wire logic [LANES-1:0] dqs_t,
	input wire logic [LANES-1:0] dqs_c,
	input wire logic [LANES-1:0] byte_invert_mask
);
	// Everything here is judged on the rising link clock
	default clocking cb @(posedge clock_true);
	endclocking
	default disable iff (!reset_n);

	// Command beats as the die samples them
	sequence s_rd_cmd;
		cke && cs && cmd_addr_bus[5:3] == OP_RD;
	endsequence
	sequence s_wr_cmd;
		cke && cs && cmd_addr_bus[5:3] == OP_WR;
	endsequence
	// Strobe preamble, one data beat, then release
	sequence s_rd_beats;
		(d_oe && dqs_t == '0) ##1 (d_oe && dqs_t == '1) ##1 !d_oe;
	endsequence
	sequence s_wr_beats;
		(h_oe && dqs_t == '0) ##1 (h_oe && dqs_t == '1) ##1 !h_oe;
	endsequence

	a_no_contention: assert property (!(h_oe && d_oe))
		else $error("both ends drive the data group");
	a_read_burst: assert property (s_rd_cmd |-> ##2 s_rd_beats)
		else $error("read strobe or release out of place");
	a_write_burst: assert property (s_wr_cmd |-> ##1 s_wr_beats)
		else $error("write strobe does not lead the data");
	a_strobe_diff: assert property ((d_oe || h_oe) |-> dqs_c == ~dqs_t)
		else $error("strobe pair not complementary");
	a_lane_strobes: assert property ((d_oe || h_oe) |-> dqs_t[0] == dqs_t[1])
		else $error("lane strobes disagree");
	a_pdown_quiet: assert property (!cke |=> !d_oe)
		else $error("die drives while clock enable is low");
	a_sleep_no_cmd: assert property (!cke |-> !cs)
		else $error("command beat while clock enable is low");
	// A flagged lane 1 read beat must carry the inverted, sparser byte
	a_dbi_flag: assert property (d_oe && dqs_t[1] && byte_invert_mask[1]
		|-> $countones(dq[15:8]) < LANE_W - INV_LIMIT)
		else $error("flagged read lane is not inverted");
	// Reset has to leave every driver off, whatever was running
	a_reset_quiet: assert property (disable iff (1'b0)
		$rose(reset_n) |-> !d_oe && !h_oe)
		else $error("driver still on when reset ends");
endmodule : lpc_link_assertions

// >>> verif/lpddr4_channel_pin_interface_tb.sv
// Bench joining controller and die ends of one channel
`timescale 1ns/1ns
module lpddr4_channel_pin_interface_tb import lpc_pkg::*; ;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd_op = 2'h0;
	logic [COL_W-1:0] cmd_col = 10'h000;
	logic [DQ_W-1:0] cmd_wdata = 16'h0000;
	logic [LANES-1:0] cmd_wmask = 2'h0;
	logic [1:0] cmd_mr_idx = 2'h0;
	logic [CA_W-1:0] cmd_mr_data = 6'h00;
	logic dbi_en = 1'b0;
	logic mask_mode = 1'b0;
	logic cmd_termination_ctrl_req = 1'b0;
	logic sleep = 1'b0;
	logic lp4x_mode = 1'b0;
	logic cmd_ready, rdata_valid, power_down, ca_term_on, cs_term_on, ck_term_on;
	logic [DQ_W-1:0] rdata;
	logic [CA_W-1:0] last_cmd;
	logic [DQ_W-1:0] w_dq = 16'h0000;
	logic [LANES-1:0] w_dmi = 2'h0;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;

	// 25 MHz system clock
	always #20 clock = ~clock;

	lpc_link_if lk ();
	lpc_host lpc_host_i (.clock(clock), .rst_n(rst_n), .link(lk.host), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_col(cmd_col), .cmd_wdata(cmd_wdata),
		.cmd_wmask(cmd_wmask), .cmd_mr_idx(cmd_mr_idx), .cmd_mr_data(cmd_mr_data),
		.dbi_en(dbi_en), .mask_mode(mask_mode), .cmd_termination_ctrl_req(cmd_termination_ctrl_req), .sleep(sleep),
		.rdata(rdata), .rdata_valid(rdata_valid));
	lpc_device lpc_device_i (.link(lk.dev), .lp4x_mode(lp4x_mode), .power_down(power_down),
		.ca_term_on(ca_term_on), .cs_term_on(cs_term_on), .ck_term_on(ck_term_on),
		.last_cmd(last_cmd));
	lpc_link_assertions lpc_link_assertions_i (.clock_true(lk.clock_true),
		.reset_n(lk.reset_n), .cke(lk.cke), .cs(lk.cs), .cmd_addr_bus(lk.cmd_addr_bus),
		.h_oe(lk.h_oe), .d_oe(lk.d_oe), .dq(lk.dq), .dqs_t(lk.dqs_t), .dqs_c(lk.dqs_c),
		.byte_invert_mask(lk.byte_invert_mask));

	// Grab the die's read beat off the wire, away from the edges
	always @(negedge clock) begin
		if (lk.d_oe === 1'b1 && lk.dqs_t[0] === 1'b1) begin
			w_dq <= lk.dq;
			w_dmi <= lk.byte_invert_mask;
		end
	end

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("[ERR] run cycles exp below %0d got %0d", 20000, cycles);
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk_w(string what, logic [DQ_W-1:0] exp, logic [DQ_W-1:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask : chk_w

	task automatic chk_b(string what, logic exp, logic got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %b got %b", what, exp, got);
		end
	endtask : chk_b

	task automatic wt(int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : wt

	// One user request; for mode writes col[1:0] is the index, d[5:0] the value
	task automatic go(logic [1:0] op, logic [COL_W-1:0] col, logic [DQ_W-1:0] d);
		int n;
		n = 0;
		@(posedge clock);
		#2;
		cmd_op = op;
		cmd_col = col;
		cmd_wdata = d;
		cmd_mr_idx = col[1:0];
		cmd_mr_data = d[5:0];
		cmd_valid = 1'b1;
		// Ready is a clean level at the falling edge; the next rise takes it
		do begin
			@(negedge clock);
			n++;
		end while (cmd_ready !== 1'b1 && n < 200);
		if (n >= 200) chk_b("cmd_ready", 1'b1, cmd_ready);
		@(posedge clock);
		#2;
		cmd_valid = 1'b0;
		if (op == HOP_MRW) wt(12);
	endtask : go

	task automatic rd(logic [COL_W-1:0] col, logic [DQ_W-1:0] exp);
		int n;
		n = 0;
		go(HOP_RD, col, 16'h0000);
		do begin
			@(negedge clock);
			n++;
		end while (rdata_valid !== 1'b1 && n < 20);
		chk_b("rdata_valid", 1'b1, rdata_valid);
		chk_w("rdata", exp, rdata);
	endtask : rd

	task automatic t_rw();
		go(HOP_WR, 10'h00F, 16'hA5C3);
		go(HOP_WR, 10'h010, 16'h3C5A);
		rd(10'h00C, 16'hA5C3);
		rd(10'h010, 16'h3C5A);
		chk_w("read wire", 16'h3C5A, w_dq);
		chk_w("last cmd", {10'h000, OP_RD, 3'h4}, {10'h000, last_cmd});
		$display("t_rw done");
	endtask : t_rw

	// Lane 0 holds exactly four ones: the boundary stays uninverted
	task automatic t_dbi();
		go(HOP_WR, 10'h008, 16'hFF0F);
		rd(10'h008, 16'hFF0F);
		chk_w("wire plain", 16'hFF0F, w_dq);
		chk_w("flags plain", 16'h0000, {14'h0000, w_dmi});
		go(HOP_MRW, {8'h00, MR_DATA}, 16'h0001);
		dbi_en = 1'b1;
		go(HOP_WR, 10'h008, 16'hFF0F);
		rd(10'h008, 16'hFF0F);
		chk_w("wire inverted", 16'h000F, w_dq);
		chk_w("flags inverted", 16'h0002, {14'h0000, w_dmi});
		$display("t_dbi done");
	endtask : t_dbi

	task automatic t_mask();
		go(HOP_MRW, {8'h00, MR_DATA}, 16'h0002);
		dbi_en = 1'b0;
		mask_mode = 1'b1;
		cmd_wmask = 2'h1;
		go(HOP_WR, 10'h008, 16'h1234);
		cmd_wmask = 2'h0;
		rd(10'h008, 16'h120F);
		go(HOP_MRW, {8'h00, MR_DATA}, 16'h0000);
		mask_mode = 1'b0;
		$display("t_mask done");
	endtask : t_mask

	task automatic t_term();
		cmd_termination_ctrl_req = 1'b1;
		go(HOP_MRW, {8'h00, MR_TERM}, 16'h0001);
		chk_b("ca term pin on", 1'b1, ca_term_on);
		cmd_termination_ctrl_req = 1'b0;
		wt(8);
		chk_b("ca term pin off", 1'b0, ca_term_on);
		lp4x_mode = 1'b1;
		cmd_termination_ctrl_req = 1'b1;
		go(HOP_MRW, {8'h00, MR_TERMX}, 16'h0003);
		chk_b("ca term x off", 1'b0, ca_term_on);
		chk_b("cs term x on", 1'b1, cs_term_on);
		chk_b("ck term x on", 1'b1, ck_term_on);
		cmd_termination_ctrl_req = 1'b0;
		go(HOP_MRW, {8'h00, MR_TERMX}, 16'h0004);
		chk_b("ca term x on", 1'b1, ca_term_on);
		chk_b("cs term x off", 1'b0, cs_term_on);
		chk_b("ck term x off", 1'b0, ck_term_on);
		$display("t_term done");
	endtask : t_term

	task automatic t_sleep();
		sleep = 1'b1;
		wt(10);
		chk_b("cke asleep", 1'b0, lk.cke);
		chk_b("power down", 1'b1, power_down);
		chk_b("ready asleep", 1'b0, cmd_ready);
		sleep = 1'b0;
		wt(10);
		chk_b("awake", 1'b0, power_down);
		rd(10'h010, 16'h3C5A);
		$display("t_sleep done");
	endtask : t_sleep

	// Reset lands while a read is in flight
	task automatic t_reset();
		go(HOP_RD, 10'h010, 16'h0000);
		wt(3);
		rst_n = 1'b0;
		wt(8);
		rst_n = 1'b1;
		wt(40);
		chk_b("ca term reset", 1'b0, ca_term_on);
		chk_b("cs term reset", 1'b0, cs_term_on);
		chk_b("drivers reset", 1'b0, lk.d_oe);
		rd(10'h00C, 16'hA5C3);
		$display("t_reset done");
	endtask : t_reset

	// Main sequence
	initial begin
		wt(8);
		rst_n = 1'b1;
		t_rw();
		t_dbi();
		t_mask();
		t_term();
		t_sleep();
		t_reset();
		tally_and_finish();
	end
endmodule : lpddr4_channel_pin_interface_tb
